// ### design/ecs_pkg.sv
package ecs_pkg;

    // ------------------------------------------------------------------
    // Device size codes
    // ------------------------------------------------------------------
    localparam logic [1:0] SIZE_8K   = 2'h0;
    localparam logic [1:0] SIZE_32K  = 2'h1;
    localparam logic [1:0] SIZE_128K = 2'h2;

    // ------------------------------------------------------------------
    // Access type routing codes
    // ------------------------------------------------------------------
    localparam logic [1:0] EMA_NONE  = 2'h0;
    localparam logic [1:0] EMA_DATA  = 2'h1;
    localparam logic [1:0] EMA_MERGE = 2'h2;
    localparam logic [1:0] EMA_SPLIT = 2'h3;

    // ------------------------------------------------------------------
    // Address geometry
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W   = 24;
    localparam int unsigned NSEL     = 3;
    localparam int unsigned BIT16    = 16;
    localparam int unsigned BIT23    = 23;
    localparam int unsigned ONCHIP_EXT_DATA_RAM_TOP = 8;

    // Window size exponents: 4K, 8K, 16K, 32K
    localparam int unsigned SH_4K    = 12;
    localparam int unsigned SH_8K    = 13;
    localparam int unsigned SH_16K   = 14;
    localparam int unsigned SH_32K   = 15;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] RST_SIZE  = SIZE_8K;
    localparam logic [1:0] RST_EMA   = EMA_MERGE;

    // ------------------------------------------------------------------
    // Execution mode states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ECS_ROM_EXEC = 3'h1,
        ECS_RAM_RST  = 3'h2,
        ECS_RAM_EXEC = 3'h4
    } ecs_mode_t;

endpackage

// ### design/ecs_window.sv
`timescale 1ns/1ps

// Stage one: address window decode for one access class
module ecs_window (
    // Configuration
    input  wire logic [1:0]  i_size,
    input  wire logic        i_protect,
    input  wire logic        i_bit16_en,
    // Access
    input  wire logic        i_active,
    input  wire logic [23:0] i_addr,
    // Internal selects, active high
    output logic      [2:0]  o_sel
);

    logic [23:0] idx;
    logic        a16;

    always_comb begin
        o_sel = 3'h0;
        idx   = 24'h0;
        a16   = i_bit16_en & i_addr[ecs_pkg::BIT16];
        if (i_active) begin
            unique case (i_size)
                ecs_pkg::SIZE_8K: begin
                    idx = i_protect ? (i_addr >> ecs_pkg::SH_4K) : (i_addr >> ecs_pkg::SH_8K);
                    if (idx < 24'h3) o_sel = 3'(3'h1 << idx[1:0]);
                end
                ecs_pkg::SIZE_32K: begin
                    if (i_protect) begin
                        idx = i_addr >> ecs_pkg::SH_16K;
                        if (idx < 24'h3) o_sel = 3'(3'h1 << idx[1:0]);
                    end else begin
                        idx = i_addr >> ecs_pkg::SH_32K;
                        if (!a16 && idx == 24'h0) o_sel = 3'h1;
                        else if (!a16 && idx == 24'h1) o_sel = 3'h2;
                        else if (a16 && idx == 24'h2) o_sel = 3'h4;
                    end
                end
                ecs_pkg::SIZE_128K: o_sel = 3'h1;
                default:            o_sel = 3'h0;
            endcase
        end
    end

endmodule

// ### design/ecs_decoder.sv
`timescale 1ns/1ps

// How it works
// - Decode each access into three program and three data internal selects.
// - Windows depend on configured device size and protection setting.
// - 8K devices: 4K windows protected, 8K windows unprotected.
// - 32K devices: 16K windows protected; unprotected uses 32K windows plus bit 16.
// - 128K devices: first select always asserted, others never.
// - Program selects idle on data accesses, data selects idle on program.
// - Type 01 routes data selects to primary outputs only in ROM execution; in RAM execution it routes as 10 and 11 do.
// - Type 11 routes program to primary only in RAM execution, data to secondary only with separated RAM in RAM execution.
// - Type 10 ORs program and data onto primary in RAM execution without separated RAM; 00 is invalid.
// - All six select outputs are active low.
// - Reset enters ROM execution; boot pin picks internal loader or external ROM.
// - In ROM execution all data accesses use primary selects.
// - Entering RAM execution resets the core and fetches from RAM address 0.
// - RAM execution: code on primary; data secondary if separated, else primary.
// - ROM accesses drive program strobe low, never read or write strobes.
// - RAM accesses use primary select with read/write, never program strobe.
// - RAM extension holds variables in separated mode, secondary select, read/write.
// - ROM up to 8M, RAM spaces 16M; upper half is data or protect code.
// - Bit-16 enable turns the port pin into the seventeenth address output.
// - Port function select chooses select output or port bit per shared pin.
module ecs_decoder (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    // Configuration
    input  wire logic [1:0]  i_memory_size_config_reg,
    input  wire logic        i_memory_protect_ctrl_reg,
    input  wire logic [1:0]  i_ext_access_type,
    input  wire logic        i_addr_bit16_enable,
    input  wire logic        i_addr_bit23_enable,
    input  wire logic [5:0]  i_port_function_select_reg,
    input  wire logic        i_separated_ram,
    input  wire logic        i_onchip_ext_data_ram,
    // Mode control
    input  wire logic        i_enter_ram_exec,
    input  wire logic        i_boot_source_pin,
    // Core bus request
    input  wire logic [23:0] i_addr,
    input  wire logic        i_code_fetch,
    input  wire logic        i_data_read,
    input  wire logic        i_data_write,
    // Port fallback data
    input  wire logic [5:0]  i_port_out,
    input  wire logic        i_port_p07_out,
    // Memory strobes
    output logic             o_prog_strobe_n,
    output logic             o_read_strobe_n,
    output logic             o_write_strobe_n,
    // Select outputs and the shared P07 pin
    output logic             o_primary_sel_0_n,
    output logic             o_primary_sel_1_n,
    output logic             o_primary_sel_2_n,
    output logic             o_secondary_sel_0_n,
    output logic             o_secondary_sel_1_n,
    output logic             o_secondary_sel_2_n,
    output logic             o_pin_p07,
    // Status
    output logic             o_ram_exec,
    output logic             o_boot_internal,
    output logic             o_core_reset,
    output logic             o_ext_data_access,
    output logic             o_config_invalid
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic boot_meta_q;
    logic boot_sync_q;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            boot_meta_q <= 1'b0;
            boot_sync_q <= 1'b0;
        end else begin
            boot_meta_q <= i_boot_source_pin;
            boot_sync_q <= boot_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Execution mode
    // ------------------------------------------------------------------
    ecs_pkg::ecs_mode_t mode_q;
    ecs_pkg::ecs_mode_t mode_d;
    logic               strap_done_q;
    logic               boot_internal_q;

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            ecs_pkg::ECS_ROM_EXEC: if (i_enter_ram_exec) mode_d = ecs_pkg::ECS_RAM_RST;
            ecs_pkg::ECS_RAM_RST:  mode_d = ecs_pkg::ECS_RAM_EXEC;
            ecs_pkg::ECS_RAM_EXEC: mode_d = ecs_pkg::ECS_RAM_EXEC;
            default:               mode_d = ecs_pkg::ECS_ROM_EXEC;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            mode_q <= ecs_pkg::ECS_ROM_EXEC;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Strap caught once, a cycle after the synchroniser output is valid
    logic [1:0] strap_wait_q;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            strap_wait_q    <= 2'h0;
            strap_done_q    <= 1'b0;
            boot_internal_q <= 1'b0;
        end else begin
            strap_wait_q <= {strap_wait_q[0], 1'b1};
            // Second flop still holds its reset value one edge after release
            if (strap_wait_q[1] && !strap_done_q) begin
                strap_done_q    <= 1'b1;
                boot_internal_q <= boot_sync_q;
            end
        end
    end

    assign o_ram_exec      = (mode_q == ecs_pkg::ECS_RAM_EXEC);
    assign o_core_reset    = (mode_q == ecs_pkg::ECS_RAM_RST);
    assign o_boot_internal = boot_internal_q;

    // ------------------------------------------------------------------
    // Address space classification
    // ------------------------------------------------------------------
    logic        ram_exec;
    logic        data_acc;
    logic        onchip_ext_data_ram_hit;
    logic        ext_data;
    logic        use_secondary;
    logic        code_on_ram;
    logic [23:0] fetch_addr;

    assign ram_exec  = (mode_q == ecs_pkg::ECS_RAM_EXEC);
    assign data_acc  = i_data_read | i_data_write;
    // On-chip data RAM shadows the low page; loader must turn it off
    assign onchip_ext_data_ram_hit  = i_onchip_ext_data_ram &
                       (i_addr[ecs_pkg::ADDR_W-1:ecs_pkg::ONCHIP_EXT_DATA_RAM_TOP] == 16'h0);
    assign ext_data  = data_acc & ~onchip_ext_data_ram_hit & ~i_code_fetch;
    // ROM space is 8M, so code never reaches the upper half
    assign fetch_addr = {1'b0, i_addr[ecs_pkg::BIT23-1:0]};
    assign code_on_ram = ram_exec & i_code_fetch;
    // Fetches always drop bit 23; data drops it only with the bit-23 enable, else upper-half data reaches a select only on 128K devices
    assign use_secondary = ram_exec & i_separated_ram & ext_data;
    assign o_ext_data_access = ext_data;

    // ------------------------------------------------------------------
    // Stage one decode
    // ------------------------------------------------------------------
    logic [2:0]  prog_sel;
    logic [2:0]  data_sel;
    logic [23:0] data_addr;

    assign data_addr = i_addr_bit23_enable ? {1'b0, i_addr[ecs_pkg::BIT23-1:0]} : i_addr;

    ecs_window u_prog_win (
        .i_size     (i_memory_size_config_reg),
        .i_protect  (i_memory_protect_ctrl_reg),
        .i_bit16_en (i_addr_bit16_enable),
        .i_active   (i_code_fetch & ~data_acc),
        .i_addr     (fetch_addr),
        .o_sel      (prog_sel)
    );

    ecs_window u_data_win (
        .i_size     (i_memory_size_config_reg),
        .i_protect  (i_memory_protect_ctrl_reg),
        .i_bit16_en (i_addr_bit16_enable),
        .i_active   (ext_data),
        .i_addr     (data_addr),
        .o_sel      (data_sel)
    );

    // ------------------------------------------------------------------
    // Stage two routing
    // ------------------------------------------------------------------
    logic [2:0] prim;
    logic [2:0] secd;

    always_comb begin
        prim = 3'h0;
        secd = 3'h0;
        unique case (i_ext_access_type)
            ecs_pkg::EMA_DATA:  prim = data_sel;
            ecs_pkg::EMA_SPLIT: begin
                prim = prog_sel;
                secd = data_sel;
            end
            ecs_pkg::EMA_MERGE: prim = prog_sel | data_sel;
            default:            prim = 3'h0;
        endcase
        // ROM fetches are marked by the program strobe, not a RAM select
        if (!code_on_ram) begin
            prim = prim & ~prog_sel & {3{i_ext_access_type != ecs_pkg::EMA_SPLIT}} | (prim & ~prog_sel);
        end
        // RAM execution: code rides the primary selects
        if (code_on_ram) begin
            prim = prog_sel;
        end
        // Data steering by mode and RAM arrangement
        if (ext_data) begin
            if (use_secondary) begin
                prim = 3'h0;
                secd = data_sel;
            end else begin
                prim = data_sel;
                secd = 3'h0;
            end
        end
        // Invalid type drives no select, whatever the mode
        if (i_ext_access_type == ecs_pkg::EMA_NONE) begin
            prim = 3'h0;
            secd = 3'h0;
        end
    end

    assign o_config_invalid = (i_ext_access_type == ecs_pkg::EMA_NONE);

    // ------------------------------------------------------------------
    // Strobes
    // ------------------------------------------------------------------
    // Combinational so they track the request with the selects
    assign o_prog_strobe_n  = ~(i_code_fetch & ~ram_exec & ~data_acc);
    assign o_read_strobe_n  = ~((i_data_read & ext_data) | (i_code_fetch & ram_exec));
    assign o_write_strobe_n = ~(i_data_write & ext_data);

    // ------------------------------------------------------------------
    // Pin function mux
    // ------------------------------------------------------------------
    // Selects stay combinational so they cover the whole strobe
    logic [5:0] sel_n;

    assign sel_n = ~{secd, prim};

    assign o_primary_sel_0_n   = i_port_function_select_reg[0] ? sel_n[0] : i_port_out[0];
    assign o_primary_sel_1_n   = i_port_function_select_reg[1] ? sel_n[1] : i_port_out[1];
    assign o_primary_sel_2_n   = i_port_function_select_reg[2] ? sel_n[2] : i_port_out[2];
    assign o_secondary_sel_0_n = i_port_function_select_reg[3] ? sel_n[3] : i_port_out[3];
    assign o_secondary_sel_1_n = i_port_function_select_reg[4] ? sel_n[4] : i_port_out[4];
    assign o_secondary_sel_2_n = i_port_function_select_reg[5] ? sel_n[5] : i_port_out[5];
    assign o_pin_p07 = i_addr_bit16_enable ? i_addr[ecs_pkg::BIT16] : i_port_p07_out;

endmodule

// ### test/ecs_decoder_sva.sv
`timescale 1ns/1ps
// ----
// Port checks
// ----
module ecs_decoder_chk (
    // Clock, reset, config
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic [1:0]  i_memory_size_config_reg,
    input  wire logic [1:0]  i_ext_access_type,
    input  wire logic        i_addr_bit16_enable,
    input  wire logic [5:0]  i_port_function_select_reg,
    // Requests
    input  wire logic        i_enter_ram_exec,
    input  wire logic [23:0] i_addr,
    input  wire logic        i_code_fetch,
    input  wire logic        i_data_read,
    // Outputs watched
    input  wire logic        o_prog_strobe_n,
    input  wire logic        o_read_strobe_n,
    input  wire logic        o_write_strobe_n,
    input  wire logic        o_primary_sel_0_n,
    input  wire logic        o_primary_sel_1_n,
    input  wire logic        o_primary_sel_2_n,
    input  wire logic        o_secondary_sel_0_n,
    input  wire logic        o_secondary_sel_1_n,
    input  wire logic        o_secondary_sel_2_n,
    input  wire logic        o_pin_p07,
    input  wire logic        o_ram_exec,
    input  wire logic        o_core_reset
);
    logic [2:0] pri_n;
    logic [2:0] sec_n;
    logic       all_cs;
    assign pri_n  = {o_primary_sel_2_n, o_primary_sel_1_n, o_primary_sel_0_n};
    assign sec_n  = {o_secondary_sel_2_n, o_secondary_sel_1_n, o_secondary_sel_0_n};
    assign all_cs = &i_port_function_select_reg;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    a_pulse_once: assert property (o_core_reset |=> !o_core_reset)
        else $error("core reset pulse too long");
    a_ram_entry: assert property (o_core_reset |=> o_ram_exec)
        else $error("ram mode not entered");
    a_enter_taken: assert property (!o_ram_exec && !o_core_reset && i_enter_ram_exec |=> o_core_reset)
        else $error("mode request ignored");
    a_ram_sticky: assert property (!$fell(o_ram_exec))
        else $error("ram mode dropped");
    a_rom_strobe: assert property (!o_prog_strobe_n |-> o_read_strobe_n && o_write_strobe_n)
        else $error("rd or wr with program strobe");
    a_rom_fetch: assert property (i_code_fetch && !o_ram_exec && !o_core_reset |-> !o_prog_strobe_n)
        else $error("rom fetch without program strobe");
    a_ram_no_prog: assert property (o_ram_exec |-> o_prog_strobe_n)
        else $error("program strobe in ram mode");
    a_type_none: assert property (i_ext_access_type == 2'h0 && all_cs |-> &{pri_n, sec_n})
        else $error("select under invalid type");
    a_data_only: assert property (i_ext_access_type == 2'h1 && all_cs |-> &sec_n && (!i_code_fetch || &pri_n))
        else $error("type 01 routing wrong");
    a_big_device: assert property (i_memory_size_config_reg == 2'h2 && o_ram_exec && i_code_fetch
        && i_ext_access_type == 2'h3 && all_cs |-> pri_n == 3'h6)
        else $error("large device select wrong");
    a_p07_addr: assert property (i_addr_bit16_enable |-> o_pin_p07 == i_addr[16])
        else $error("bit 16 pin wrong");

    c_mode: cover property (o_core_reset);
    c_big: cover property (i_memory_size_config_reg == 2'h2 && o_ram_exec && i_code_fetch);
    c_none: cover property (i_ext_access_type == 2'h0 && i_data_read);
endmodule

bind ecs_decoder ecs_decoder_chk u_chk (.i_clock(i_clock), .i_resetn(i_resetn),
    .i_memory_size_config_reg(i_memory_size_config_reg), .i_ext_access_type(i_ext_access_type),
    .i_addr_bit16_enable(i_addr_bit16_enable), .i_port_function_select_reg(i_port_function_select_reg),
    .i_enter_ram_exec(i_enter_ram_exec), .i_addr(i_addr), .i_code_fetch(i_code_fetch), .i_data_read(i_data_read),
    .o_prog_strobe_n(o_prog_strobe_n), .o_read_strobe_n(o_read_strobe_n), .o_write_strobe_n(o_write_strobe_n),
    .o_primary_sel_0_n(o_primary_sel_0_n), .o_primary_sel_1_n(o_primary_sel_1_n),
    .o_primary_sel_2_n(o_primary_sel_2_n), .o_secondary_sel_0_n(o_secondary_sel_0_n),
    .o_secondary_sel_1_n(o_secondary_sel_1_n), .o_secondary_sel_2_n(o_secondary_sel_2_n),
    .o_pin_p07(o_pin_p07), .o_ram_exec(o_ram_exec), .o_core_reset(o_core_reset));

// ### test/ecs_mem_model.sv
`timescale 1ns/1ps
// ----
// Memory chips on the board, counting accesses
// ----
module ecs_mem_model (
    // Clock and strobes
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic        i_prog_strobe_n,
    input  wire logic        i_read_strobe_n,
    input  wire logic        i_write_strobe_n,
    // Selects as wired
    input  wire logic [2:0]  i_primary_sel_n,
    input  wire logic [2:0]  i_secondary_sel_n,
    // Access counts
    output logic      [15:0] o_rom_hits,
    output logic      [15:0] o_ram_hits,
    output logic      [15:0] o_ext_hits
);
    logic rw;
    assign rw = !(i_read_strobe_n && i_write_strobe_n);
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rom_hits <= 16'h0;
            o_ram_hits <= 16'h0;
            o_ext_hits <= 16'h0;
        end else begin
            if (!i_prog_strobe_n) o_rom_hits <= o_rom_hits + 16'h1;
            if (rw && !(&i_primary_sel_n)) o_ram_hits <= o_ram_hits + 16'h1;
            if (rw && !(&i_secondary_sel_n)) o_ext_hits <= o_ext_hits + 16'h1;
        end
    end
endmodule

// ### test/tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin mismatches++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
    logic        i_clock, i_resetn, prot, b16, a23, sep, onchip, enter, boot, p07, rm;
    logic [1:0]  size, ty, op;
    logic [5:0]  pfs, pout, cs_n;
    logic [23:0] addr;
    logic        prog_n, rd_n, wr_n, pin07, ram_exec, boot_int, core_rst, ext_acc, invalid;
    logic [15:0] rom_hits, ram_hits, ext_hits;
    int          mismatches, tests_run;

    ecs_decoder dut (.i_clock(i_clock), .i_resetn(i_resetn), .i_memory_size_config_reg(size),
        .i_memory_protect_ctrl_reg(prot), .i_ext_access_type(ty), .i_addr_bit16_enable(b16),
        .i_addr_bit23_enable(a23), .i_port_function_select_reg(pfs), .i_separated_ram(sep),
        .i_onchip_ext_data_ram(onchip), .i_enter_ram_exec(enter), .i_boot_source_pin(boot), .i_addr(addr),
        .i_code_fetch(op == 2'h0), .i_data_read(op == 2'h1), .i_data_write(op == 2'h2), .i_port_out(pout),
        .i_port_p07_out(p07), .o_prog_strobe_n(prog_n), .o_read_strobe_n(rd_n), .o_write_strobe_n(wr_n),
        .o_primary_sel_0_n(cs_n[0]), .o_primary_sel_1_n(cs_n[1]), .o_primary_sel_2_n(cs_n[2]),
        .o_secondary_sel_0_n(cs_n[3]), .o_secondary_sel_1_n(cs_n[4]), .o_secondary_sel_2_n(cs_n[5]),
        .o_pin_p07(pin07), .o_ram_exec(ram_exec), .o_boot_internal(boot_int), .o_core_reset(core_rst),
        .o_ext_data_access(ext_acc), .o_config_invalid(invalid));
    ecs_mem_model mem (.i_clock(i_clock), .i_resetn(i_resetn), .i_prog_strobe_n(prog_n),
        .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_primary_sel_n(cs_n[2:0]),
        .i_secondary_sel_n(cs_n[5:3]), .o_rom_hits(rom_hits), .o_ram_hits(ram_hits), .o_ext_hits(ext_hits));

    // ----
    // Expected window per size and protection
    // ----
    function automatic logic [2:0] win(input logic [23:0] a);
        int sh;
        sh = prot ? 12 : 13;
        if (size == 2'h1) sh = 14;
        if (size == 2'h2) return 3'h1;
        if (size == 2'h3) return 3'h0;
        if (size == 2'h1 && !prot) begin
            if (a[22:17] != 6'h0) return 3'h0;
            return {a[16] & !a[15], !a[16] & a[15], !a[16] & !a[15]};
        end
        if ((a[22:0] >> sh) > 23'h2) return 3'h0;
        return 3'h1 << (a[22:0] >> sh);
    endfunction

    task automatic check();
        logic       d, intr;
        logic [2:0] w, pg, dt, pri, sec;
        d    = op[0] ^ op[1];
        intr = onchip && d && addr < 24'h100;
        w    = (intr || op == 2'h3) ? 3'h0 : win(addr);
        pg   = (op == 2'h0 && rm) ? w : 3'h0;
        dt   = d ? w : 3'h0;
        pri  = ty == 2'h1 ? dt : ty == 2'h2 ? (pg | dt) : ty == 2'h3 ? pg : 3'h0;
        sec  = ty == 2'h3 ? dt : 3'h0;
        `CHK(cs_n, (pfs & ~{sec, pri}) | (~pfs & pout))
        `CHK({prog_n, rd_n, wr_n}, ~{op == 2'h0 && !rm, (op == 2'h1 && !intr) || (op == 2'h0 && rm), op == 2'h2 && !intr})
        `CHK(pin07, b16 ? addr[16] : p07)
        `CHK({ext_acc, invalid, ram_exec}, {d && !intr, ty == 2'h0, rm})
    endtask

    task automatic step(input logic m);
        logic [1:0]  o, t;
        logic [23:0] a;
        logic        b, s, e;
        o = 2'($urandom);
        b = 1'($urandom);
        s = 1'($urandom);
        e = 1'($urandom);
        t = m ? (s ? 2'h3 : 2'h2) : 2'($urandom % 3);
        a = 24'($urandom) & 24'h1FFFF;
        if (!b) a[16] = 1'b0;
        if ($urandom % 8 == 0) a = 24'h0000FF;
        if (o[0] ^ o[1]) a[23] = e & 1'($urandom);
        @(posedge i_clock);
        op <= o; b16 <= b; sep <= s; a23 <= e; ty <= t; addr <= a;
        size <= 2'($urandom); prot <= 1'($urandom); onchip <= 1'($urandom);
        pfs <= ($urandom % 4 == 0) ? 6'($urandom) : 6'h3F;
        pout <= 6'($urandom);
        p07 <= 1'($urandom);
        @(negedge i_clock);
        check();
    endtask

    task automatic end_sim();
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    initial begin
        repeat (20000) @(posedge i_clock);
        mismatches++;
        end_sim();
    end

    initial begin
        void'($urandom(32'h2771));
        mismatches = 0; tests_run = 0; rm = 1'b0; i_resetn = 1'b0; boot = 1'b1; enter = 1'b0;
        op = 2'h3; size = 2'h0; prot = 1'b0; b16 = 1'b0; a23 = 1'b0; sep = 1'b0; onchip = 1'b0;
        ty = 2'h2; pfs = 6'h3F; pout = 6'h0; p07 = 1'b0; addr = 24'h0;
        repeat (16) @(posedge i_clock);
        i_resetn <= 1'b1;
        repeat (6) @(negedge i_clock);
        `CHK({boot_int, ram_exec}, 2'h2)
        repeat (300) step(1'b0);
        @(posedge i_clock);
        op <= 2'h3;
        enter <= 1'b1;
        @(posedge i_clock);
        enter <= 1'b0;
        @(negedge i_clock);
        `CHK(core_rst, 1'b1)
        @(negedge i_clock);
        rm = 1'b1;
        `CHK({core_rst, ram_exec}, 2'h1)
        repeat (300) step(1'b1);
        `CHK(rom_hits != 16'h0 && ram_hits != 16'h0 && ext_hits != 16'h0, 1'b1)
        @(posedge i_clock);
        i_resetn <= 1'b0;
        boot <= 1'b0;
        rm = 1'b0;
        repeat (16) @(posedge i_clock);
        i_resetn <= 1'b1;
        repeat (6) @(negedge i_clock);
        `CHK({boot_int, ram_exec}, 2'h0)
        end_sim();
    end
endmodule
